// ===== hw/fan_pwm_gen.sv
// open-drain fan drive waveform generator on a 3.2 MHz tick
`timescale 1ns/1ns
module fan_pwm_gen
    import fan_alarm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       clear_i,
    input  wire logic       enable_i,
    input  wire logic       invert_i,
    input  wire logic [7:0] duty_i,
    input  wire logic       high_range_i,
    input  wire logic [2:0] freq_sel_i,
    output logic            drv_o,
    output logic            drv_oe_o
);
    logic [9:0]           phase_ff;
    logic [10:0]          nxt_phase;
    logic                 tick;
    logic [PERIOD_W-1:0]  cnt_ff;
    logic [PERIOD_W-1:0]  period_ff;
    logic [PERIOD_W-1:0]  on_ticks_ff;
    logic [PERIOD_W-1:0]  nxt_period;
    logic [PERIOD_W+7:0]  product;
    logic                 active;

    // fractional divider: 100 MHz / 31.25, jitter of one clock per tick
    assign nxt_phase = {1'b0, phase_ff} + {1'b0, TICK_STEP};  // [RULE22]
    assign tick = nxt_phase >= {1'b0, TICK_MOD};
    assign nxt_period = PERIOD_W'(PWM_PERIOD_TICKS[{high_range_i, freq_sel_i}]);  // [RULE20] [RULE21]
    assign product = nxt_period * duty_i;
    assign active = cnt_ff < on_ticks_ff;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            phase_ff <= 10'h000;
        else if (clear_i)
            phase_ff <= 10'h000;
        else if (tick)
            phase_ff <= 10'(nxt_phase - {1'b0, TICK_MOD});
        else
            phase_ff <= nxt_phase[9:0];
    end

    // duty and frequency are taken at the period boundary to avoid runt pulses
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_ff      <= '0;
            period_ff   <= '0;
            on_ticks_ff <= '0;
        end
        else if (clear_i)
        begin
            cnt_ff      <= '0;
            period_ff   <= '0;
            on_ticks_ff <= '0;
        end
        else if (tick)
        begin
            if (cnt_ff + 1'b1 >= period_ff)
            begin
                cnt_ff      <= '0;
                period_ff   <= nxt_period;
                on_ticks_ff <= PERIOD_W'(product / 8'hff);  // [RULE18]
            end
            else
                cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            drv_o    <= 1'b0;
            drv_oe_o <= 1'b0;
        end
        else
        begin
            drv_o    <= 1'b0;
            drv_oe_o <= enable_i & (active ^ invert_i) & ~clear_i;  // [RULE16] [RULE17]
        end
    end

    chk_fan_drive_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !enable_i |=> !drv_oe_o)  // [RULE16]
        else $error("fan drive not released while disabled");
endmodule

// ===== hw/temp_limit_alarm.sv
// temperature limit alarms, status registers and fan drive control
// Summary of operation
// RULE1: set high flag when channel temperature is at or above its high limit.
// RULE2: set low flag when channel temperature is at or below its low limit.
// RULE3: local high or low sets local range flag; alert only if enabled.
// RULE4: remote high or low sets remote range flag; alert only if enabled.
// RULE5: at or above critical limit set flag, pull alarm pin low, unmaskable alert.
// RULE6: auto remote mode: remote at or below passive limit stops fan.
// RULE7: max-speed mode: both temperatures at or below passive limit stop fan.
// RULE8: passive cooling sets its flag in second status; alert if enabled.
// RULE9: reading second status clears passive flag; it resets next cycle if still true.
// RULE10: at or above throttle limit set flag, pull throttle pin low, alert if enabled.
// RULE11: reading first status clears throttle flags; rearm only 5 degrees below limit.
// RULE12: throttle flags never change the fan duty, whatever throttle fan enable says.
// RULE13: detect open, ground short, pin short only after first monitoring cycle.
// RULE14: faulty remote reads as code 0x80; temperature registers reset to 0x80.
// RULE15: sensor fault sets flag and alarm pin low, held until any reset.
// RULE16: fan drive disabled means released; enabled follows duty and polarity.
// RULE17: polarity clear pulls low at full duty; set releases high at full duty.
// RULE18: 8-bit duty, steps of 1/255, 0x00 is 0 and 0xff is 100 percent.
// RULE19: range pin grounded selects high range, floating or high selects low range.
// RULE20: low range values give 10 to 94 Hz, default 30 Hz.
// RULE21: high range values give 1 to 40 kHz, default 25 kHz.
// RULE22: waveform period counted in ticks of a 3.2 MHz clock.
// RULE23: results are 11-bit two's complement, eight msbs high byte, three lsbs low.
// RULE24: alert pulled low while any enabled or critical condition pends.
// RULE25: all comparisons once per completed monitoring cycle on newest results.
`timescale 1ns/1ns
module temp_limit_alarm
    import fan_alarm_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        MON_DONE_I,
    input  wire logic [10:0] LOCAL_TEMP_I,
    input  wire logic [10:0] REMOTE_TEMP_I,
    input  wire logic        DIODE_OPEN_I,
    input  wire logic        DIODE_SHORT_GND_I,
    input  wire logic        DIODE_SHORT_PINS_I,
    input  wire logic        RANGE_SEL_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic        REG_WR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic        REG_RD_I,
    output logic      [7:0]  REG_RDATA_O,
    output logic             CRITICAL_ALARM_PIN_N_O,
    output logic             CLOCK_THROTTLE_PIN_N_O,
    input  wire logic        ALERT_I,
    output logic             ALERT_O,
    output logic             ALERT_OE_O,
    input  wire logic        FAN_DRV_I,
    output logic             FAN_DRV_O,
    output logic             FAN_DRV_OE_O
);
    import fan_alarm_pkg::*;

    logic        soft_rst_ff;
    logic [7:0]  cfg1_ff;
    logic [7:0]  cfg2_ff;
    logic [7:0]  cfg3_ff;
    logic [7:0]  duty_cycle_value_ff;
    logic [7:0]  fanchar_ff;
    logic [7:0]  lim_ff [NUM_LIM];
    logic [10:0] local_temp_ff;
    logic [10:0] remote_temp_ff;
    logic [7:0]  st1_ff;
    logic [7:0]  st2_ff;
    logic [1:0]  thr_armed_ff;
    logic [1:0]  thr_lvl_ff;
    logic [1:0]  crit_lvl_ff;
    logic        passive_lvl_ff;
    logic        first_done_ff;
    logic [7:0]  nxt_rdata;
    logic [7:0]  set1;
    logic [7:0]  set2;
    logic        rd_st1;
    logic        rd_st2;
    logic        fault_now;
    logic signed [7:0] ltemp;
    logic signed [7:0] rtemp;
    logic signed [8:0] thr_rearm_lvl;
    logic [1:0]  thr_hit;
    logic [1:0]  thr_rearm;
    logic        passive_now;
    logic        alert_pend;
    logic [7:0]  fan_duty;
    cool_mode_e  mode;

    assign rd_st1 = REG_RD_I && (REG_ADDR_I == OFS_STATUS1);
    assign rd_st2 = REG_RD_I && (REG_ADDR_I == OFS_STATUS2);
    assign mode = cool_mode_e'(cfg2_ff[CFG2_MODE_LSB +: 2]);

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            soft_rst_ff <= 1'b0;
        else
            soft_rst_ff <= REG_WR_I && (REG_ADDR_I == OFS_CFG1) && REG_WDATA_I[CFG1_SRST];
    end

    // configuration; software reset bit is not stored, it self-clears
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            cfg1_ff             <= CFG1_RESET;
            cfg2_ff             <= CFG2_RESET;
            cfg3_ff             <= CFG3_RESET;
            duty_cycle_value_ff <= DUTY_RESET;
            fanchar_ff          <= FANCHAR_RESET;
        end
        else if (soft_rst_ff)
        begin
            cfg1_ff             <= CFG1_RESET;
            cfg2_ff             <= CFG2_RESET;
            cfg3_ff             <= CFG3_RESET;
            duty_cycle_value_ff <= DUTY_RESET;
            fanchar_ff          <= FANCHAR_RESET;
        end
        else if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                OFS_CFG1:    cfg1_ff <= REG_WDATA_I & 8'h7f;
                OFS_CFG2:    cfg2_ff <= REG_WDATA_I;
                OFS_CFG3:    cfg3_ff <= REG_WDATA_I;
                OFS_DUTY:    duty_cycle_value_ff <= REG_WDATA_I;
                OFS_FANCHAR: fanchar_ff <= REG_WDATA_I;
                default:     ;
            endcase
        end
    end

    generate
        for (genvar i = 0; i < NUM_LIM; i++)
        begin : g_lim
            always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
            begin
                if (!ARST_N_I)
                    lim_ff[i] <= LIM_RESET[i];
                else if (soft_rst_ff)
                    lim_ff[i] <= LIM_RESET[i];
                else if (REG_WR_I && (REG_ADDR_I == OFS_LIM_BASE + 8'(i)))
                    lim_ff[i] <= REG_WDATA_I;
            end
        end
    endgenerate

    // fault is only trusted once a full monitoring cycle has run
    assign fault_now = MON_DONE_I && first_done_ff &&
        (DIODE_OPEN_I || DIODE_SHORT_GND_I || DIODE_SHORT_PINS_I);  // [RULE13]
    assign ltemp = LOCAL_TEMP_I[10:3];
    assign rtemp = fault_now ? TEMP_FAULT_CODE : REMOTE_TEMP_I[10:3];  // [RULE14]

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            first_done_ff <= 1'b0;
        else if (soft_rst_ff)
            first_done_ff <= 1'b0;
        else if (MON_DONE_I)
            first_done_ff <= 1'b1;
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            local_temp_ff  <= TEMP_RESET;  // [RULE14]
            remote_temp_ff <= TEMP_RESET;
        end
        else if (soft_rst_ff)
        begin
            local_temp_ff  <= TEMP_RESET;
            remote_temp_ff <= TEMP_RESET;
        end
        else if (MON_DONE_I)
        begin
            local_temp_ff  <= LOCAL_TEMP_I;  // [RULE23]
            remote_temp_ff <= fault_now ? TEMP_RESET : REMOTE_TEMP_I;  // [RULE14]
        end
    end

    assign thr_rearm_lvl = $signed({lim_ff[LIM_THR][7], lim_ff[LIM_THR]})
        - 9'(THROTTLE_HYST_DEG);
    assign thr_hit[0] = ltemp >= $signed(lim_ff[LIM_THR]);  // [RULE10]
    assign thr_hit[1] = rtemp >= $signed(lim_ff[LIM_THR]);
    assign thr_rearm[0] = MON_DONE_I && ($signed({ltemp[7], ltemp}) < thr_rearm_lvl);  // [RULE11]
    assign thr_rearm[1] = MON_DONE_I && ($signed({rtemp[7], rtemp}) < thr_rearm_lvl);

    always_comb
    begin
        set1 = 8'h00;
        set2 = 8'h00;
        passive_now = 1'b0;
        case (mode)
            MODE_AUTO_REMOTE: passive_now = rtemp <= $signed(lim_ff[LIM_PSV]);  // [RULE6]
            MODE_MAX_SPEED:   passive_now = (rtemp <= $signed(lim_ff[LIM_PSV])) &&
                                            (ltemp <= $signed(lim_ff[LIM_PSV]));  // [RULE7]
            default:          passive_now = 1'b0;
        endcase
        if (MON_DONE_I)  // [RULE25]
        begin
            set1[ST1_LH] = ltemp >= $signed(lim_ff[LIM_LH]);  // [RULE1]
            set1[ST1_RH] = rtemp >= $signed(lim_ff[LIM_RH]);
            set1[ST1_LL] = ltemp <= $signed(lim_ff[LIM_LL]);  // [RULE2]
            set1[ST1_RL] = rtemp <= $signed(lim_ff[LIM_RL]);
            set1[ST1_LC] = ltemp >= $signed(lim_ff[LIM_LC]);  // [RULE5]
            set1[ST1_RC] = rtemp >= $signed(lim_ff[LIM_RC]);
            set1[ST1_LT] = thr_hit[0] && (thr_armed_ff[0] || thr_rearm[0]);  // [RULE11]
            set1[ST1_RT] = thr_hit[1] && (thr_armed_ff[1] || thr_rearm[1]);
            set2[ST2_LOOR] = set1[ST1_LH] || set1[ST1_LL];  // [RULE3]
            set2[ST2_ROOR] = set1[ST1_RH] || set1[ST1_RL];  // [RULE4]
            set2[ST2_FAULT] = fault_now;  // [RULE15]
            set2[ST2_PSV] = passive_now;  // [RULE8] [RULE9]
        end
    end

    // set wins over clear-on-read; fault flag ignores reads
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            st1_ff <= 8'h00;
            st2_ff <= 8'h00;
        end
        else if (soft_rst_ff)
        begin
            st1_ff <= 8'h00;
            st2_ff <= 8'h00;
        end
        else
        begin
            st1_ff <= (st1_ff & ~{8{rd_st1}}) | set1;  // [RULE11]
            st2_ff <= (st2_ff & ~({8{rd_st2}} & ~(8'h01 << ST2_FAULT))) | set2;  // [RULE9] [RULE15]
        end
    end

    // a channel is disarmed only if its flag was set when status 1 was read
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            thr_armed_ff <= 2'b11;
        else if (soft_rst_ff)
            thr_armed_ff <= 2'b11;
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (thr_rearm[c])
                    thr_armed_ff[c] <= 1'b1;  // [RULE11]
                else if (rd_st1 && st1_ff[ST1_LT + c])
                    thr_armed_ff[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            thr_lvl_ff     <= 2'b00;
            crit_lvl_ff    <= 2'b00;
            passive_lvl_ff <= 1'b0;
        end
        else if (soft_rst_ff)
        begin
            thr_lvl_ff     <= 2'b00;
            crit_lvl_ff    <= 2'b00;
            passive_lvl_ff <= 1'b0;
        end
        else if (MON_DONE_I)
        begin
            thr_lvl_ff     <= thr_hit;  // [RULE10]
            crit_lvl_ff    <= {set1[ST1_RC], set1[ST1_LC]};  // [RULE5]
            passive_lvl_ff <= passive_now;  // [RULE6] [RULE7]
        end
    end

    assign alert_pend = (st2_ff[ST2_LOOR] && cfg2_ff[CFG2_LIE])  // [RULE3]
        || (st2_ff[ST2_ROOR] && cfg2_ff[CFG2_RIE])  // [RULE4]
        || st1_ff[ST1_LC] || st1_ff[ST1_RC]  // [RULE5]
        || ((st1_ff[ST1_LT] || st1_ff[ST1_RT]) && cfg1_ff[CFG1_TIE])  // [RULE10]
        || (st2_ff[ST2_PSV] && cfg2_ff[CFG2_PIE])  // [RULE8]
        || (st2_ff[ST2_FAULT] && cfg1_ff[CFG1_FIE]);  // [RULE15]

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ALERT_O                <= 1'b0;
            ALERT_OE_O             <= 1'b0;
            CRITICAL_ALARM_PIN_N_O <= 1'b1;
            CLOCK_THROTTLE_PIN_N_O <= 1'b1;
        end
        else
        begin
            ALERT_O                <= 1'b0;
            ALERT_OE_O             <= alert_pend;  // [RULE24]
            CRITICAL_ALARM_PIN_N_O <= ~(|crit_lvl_ff || st2_ff[ST2_FAULT]);  // [RULE5] [RULE15]
            CLOCK_THROTTLE_PIN_N_O <= ~(|thr_lvl_ff);  // [RULE10]
        end
    end

    // throttle state deliberately stays out of the duty path
    assign fan_duty = passive_lvl_ff ? 8'h00 : duty_cycle_value_ff;  // [RULE12] [RULE6]

    always_comb
    begin
        nxt_rdata = 8'h00;
        case (REG_ADDR_I)
            OFS_CFG1:      nxt_rdata = cfg1_ff;
            OFS_CFG2:      nxt_rdata = cfg2_ff;
            OFS_STATUS1:   nxt_rdata = st1_ff;
            OFS_STATUS2:   nxt_rdata = st2_ff;
            OFS_CFG3:      nxt_rdata = cfg3_ff;
            OFS_DUTY:      nxt_rdata = duty_cycle_value_ff;
            OFS_FANCHAR:   nxt_rdata = fanchar_ff;
            OFS_LOCAL_HI:  nxt_rdata = local_temp_ff[10:3];  // [RULE23]
            OFS_TEMP_LO:   nxt_rdata = {local_temp_ff[2:0], 2'b00, remote_temp_ff[2:0]};
            OFS_REMOTE_HI: nxt_rdata = remote_temp_ff[10:3];
            default:
            begin
                if (REG_ADDR_I >= OFS_LIM_BASE && REG_ADDR_I < OFS_LIM_BASE + 8'(NUM_LIM))
                    nxt_rdata = lim_ff[3'(REG_ADDR_I - OFS_LIM_BASE)];
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            REG_RDATA_O <= 8'h00;
        else if (REG_RD_I)
            REG_RDATA_O <= nxt_rdata;
    end

    fan_pwm_gen u_pwm (
        .clk_i        (REF_CLK_I),
        .arst_n_i     (ARST_N_I),
        .clear_i      (soft_rst_ff),
        .enable_i     (cfg2_ff[CFG2_FEN]),
        .invert_i     (cfg1_ff[CFG1_INV]),
        .duty_i       (fan_duty),
        .high_range_i (~RANGE_SEL_I),  // [RULE19]
        .freq_sel_i   (fanchar_ff[FREQ_SEL_LSB +: 3]),
        .drv_o        (FAN_DRV_O),
        .drv_oe_o     (FAN_DRV_OE_O)
    );

    chk_high_flag_set: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE1]
        MON_DONE_I && !soft_rst_ff && ltemp >= $signed(lim_ff[LIM_LH]) |=> st1_ff[ST1_LH])
        else $error("local high flag missing");
    chk_low_flag_set: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE2]
        MON_DONE_I && !soft_rst_ff && rtemp <= $signed(lim_ff[LIM_RL]) |=> st1_ff[ST1_RL])
        else $error("remote low flag missing");
    chk_range_alert: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE3]
        st2_ff[ST2_LOOR] && cfg2_ff[CFG2_LIE] |=> ALERT_OE_O)
        else $error("local range alert missing");
    chk_crit_pin_low: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE5]
        MON_DONE_I && !soft_rst_ff && set1[ST1_RC] |=> ##1 !CRITICAL_ALARM_PIN_N_O && ALERT_OE_O)
        else $error("critical pin or alert not asserted");
    chk_fault_held: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE15]
        st2_ff[ST2_FAULT] && !soft_rst_ff |=> st2_ff[ST2_FAULT])
        else $error("sensor fault flag dropped");
    chk_fault_first_cycle: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE13]
        MON_DONE_I && !first_done_ff && !st2_ff[ST2_FAULT] |=> !st2_ff[ST2_FAULT])
        else $error("fault flagged before first cycle");
    chk_throttle_rearm: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE11]
        !thr_armed_ff[0] && !thr_rearm[0] && !st1_ff[ST1_LT] |=> !st1_ff[ST1_LT])
        else $error("throttle flag set while disarmed");
    chk_passive_flag: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE8]
        MON_DONE_I && !soft_rst_ff && passive_now |=> st2_ff[ST2_PSV] && fan_duty == 8'h00)
        else $error("passive cooling not entered");
    chk_duty_passthru: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)  // [RULE12]
        !passive_lvl_ff |-> fan_duty == duty_cycle_value_ff)
        else $error("duty altered outside passive cooling");
endmodule

// ===== shared/fan_alarm_pkg.sv
// constants shared by the temperature alarm and fan drive logic
package fan_alarm_pkg;
    localparam int CLK_HZ  = 100_000_000;
    localparam int TICK_HZ = 3_200_000;
    localparam int TICK_GCD = 100_000;
    localparam logic [9:0] TICK_STEP = 10'(TICK_HZ / TICK_GCD);
    localparam logic [9:0] TICK_MOD  = 10'(CLK_HZ / TICK_GCD);
    // index is {high range, frequency_select}
    localparam int PWM_PERIOD_TICKS [16] = '{
        TICK_HZ / 10, TICK_HZ / 15, TICK_HZ / 23, TICK_HZ / 30,
        TICK_HZ / 38, TICK_HZ / 47, TICK_HZ / 62, TICK_HZ / 94,
        TICK_HZ / 1000, TICK_HZ / 10000, TICK_HZ / 20000, TICK_HZ / 25000,
        TICK_HZ / 30000, TICK_HZ / 40000, TICK_HZ / 40000, TICK_HZ / 40000};
    localparam int PERIOD_W = 19;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam int THROTTLE_HYST_DEG = 5;
    localparam logic [10:0] TEMP_RESET = 11'h400;
    localparam logic [7:0]  TEMP_FAULT_CODE = 8'h80;

    localparam logic [7:0] OFS_CFG1       = 8'h00;
    localparam logic [7:0] OFS_CFG2       = 8'h01;
    localparam logic [7:0] OFS_STATUS1    = 8'h02;
    localparam logic [7:0] OFS_STATUS2    = 8'h03;
    localparam logic [7:0] OFS_CFG3       = 8'h04;
    localparam logic [7:0] OFS_DUTY       = 8'h05;
    localparam logic [7:0] OFS_FANCHAR    = 8'h06;
    localparam logic [7:0] OFS_LOCAL_HI   = 8'h07;
    localparam logic [7:0] OFS_TEMP_LO    = 8'h08;
    localparam logic [7:0] OFS_REMOTE_HI  = 8'h09;
    localparam logic [7:0] OFS_LIM_BASE   = 8'h10;
    localparam int NUM_LIM = 8;
    localparam int LIM_LH = 0;
    localparam int LIM_LL = 1;
    localparam int LIM_LC = 2;
    localparam int LIM_RH = 3;
    localparam int LIM_RL = 4;
    localparam int LIM_RC = 5;
    localparam int LIM_PSV = 6;
    localparam int LIM_THR = 7;
    localparam logic [7:0] LIM_RESET [NUM_LIM] = '{
        8'h50, 8'hd8, 8'h64, 8'h50, 8'hd8, 8'h64, 8'h28, 8'h5a};

    localparam int CFG1_INV = 0;
    localparam int CFG1_FIE = 1;
    localparam int CFG1_TIE = 2;
    localparam int CFG1_SRST = 7;
    localparam int CFG2_FEN = 0;
    localparam int CFG2_LIE = 1;
    localparam int CFG2_RIE = 2;
    localparam int CFG2_PIE = 3;
    localparam int CFG2_MODE_LSB = 4;
    localparam int CFG3_TFE = 0;
    localparam int FREQ_SEL_LSB = 0;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic [7:0] CFG2_RESET = 8'h00;
    localparam logic [7:0] CFG3_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] FANCHAR_RESET = 8'h03;

    localparam int ST1_LH = 0;
    localparam int ST1_LL = 1;
    localparam int ST1_RH = 2;
    localparam int ST1_RL = 3;
    localparam int ST1_LC = 4;
    localparam int ST1_RC = 5;
    localparam int ST1_LT = 6;
    localparam int ST1_RT = 7;
    localparam int ST2_LOOR = 0;
    localparam int ST2_ROOR = 1;
    localparam int ST2_FAULT = 2;
    localparam int ST2_PSV = 3;

    typedef enum logic [1:0] {MODE_SOFTWARE, MODE_AUTO_REMOTE, MODE_MAX_SPEED, MODE_SPARE}
        cool_mode_e;
endpackage

// ===== verification/fan_alarm_wires.sv
// pull-up model of the fan drive and alert wires
`timescale 1ns/1ns
module fan_alarm_wires
(
    input  wire logic fan_oe_i,
    input  wire logic alert_oe_i,
    output logic      fan_pin_o,
    output logic      alert_pin_o
);
    // external pull-ups, so a released line reads a solid high
    assign fan_pin_o   = !fan_oe_i;
    assign alert_pin_o = !alert_oe_i;
endmodule

// ===== verification/temp_limit_alarm_tb.sv
// self-checking bench for the alarm and fan drive block
`timescale 1ns/1ns
module temp_limit_alarm_tb;
    import fan_alarm_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] e;} row_s;
    typedef struct {logic en; logic inv; logic [7:0] duty; logic oe;} fan_s;
    logic        clk, arst_n, mon, d_open, d_gnd, d_pins, rng, wr, rd;
    logic [10:0] lt, rt;
    logic [7:0]  addr, wdata, rdata;
    logic        crit_n, thr_n, al_o, al_oe, fan_o, fan_oe, fan_pin, al_pin;
    int          n_mismatch, n_tests, bad;
    row_s        rows [12];
    fan_s        fan [5] = '{'{0, 0, 8'hff, 0}, '{1, 0, 8'hff, 1}, '{1, 1, 8'hff, 0},
                             '{1, 0, 8'h00, 0}, '{1, 1, 8'h00, 1}};
    temp_limit_alarm temp_limit_alarm_i (.REF_CLK_I(clk), .ARST_N_I(arst_n),
        .MON_DONE_I(mon), .LOCAL_TEMP_I(lt), .REMOTE_TEMP_I(rt), .DIODE_OPEN_I(d_open),
        .DIODE_SHORT_GND_I(d_gnd), .DIODE_SHORT_PINS_I(d_pins), .RANGE_SEL_I(rng),
        .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .CRITICAL_ALARM_PIN_N_O(crit_n),
        .CLOCK_THROTTLE_PIN_N_O(thr_n), .ALERT_I(al_pin), .ALERT_O(al_o),
        .ALERT_OE_O(al_oe), .FAN_DRV_I(fan_pin), .FAN_DRV_O(fan_o), .FAN_DRV_OE_O(fan_oe));
    fan_alarm_wires fan_alarm_wires_i (.fan_oe_i(fan_oe), .alert_oe_i(al_oe),
        .fan_pin_o(fan_pin), .alert_pin_o(al_pin));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk) wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string msg);
        addr = a;
        rd = 1'b1;
        @(negedge clk) rd = 1'b0;
        chk(rdata, e, msg);
        @(negedge clk);
    endtask
    // temperatures stay on the inputs after the strobe, like a held result
    task automatic tmon(input logic [7:0] l, input logic [7:0] r);
        lt = {l, 3'h0};
        rt = {r, 3'h0};
        mon = 1'b1;
        @(negedge clk) mon = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #800_000;
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        {arst_n, mon, d_open, d_gnd, d_pins, rng, wr, rd} = '0;
        {lt, rt, addr, wdata} = '0;
        for (int i = 0; i < 8; i++)
            rows[i] = '{8'(OFS_LIM_BASE + 8'(i)), LIM_RESET[i]};
        rows[8] = '{OFS_FANCHAR, 8'h03};
        rows[9] = '{OFS_REMOTE_HI, 8'h80};
        rows[10] = '{OFS_CFG2, 8'h00};
        rows[11] = '{8'hff, 8'h00};
        repeat (6) @(negedge clk);
        chk({crit_n, thr_n, fan_oe, al_oe}, 8'h0c, "reset pins");
        arst_n = 1'b1;
        foreach (rows[i]) rreg(rows[i].a, rows[i].e, "reset value");
        tmon(8'h50, 8'hd8);
        chk(al_oe, 1'b0, "masked alert");
        wreg(OFS_CFG2, 8'h02);
        @(negedge clk);
        chk(al_pin, 1'b0, "enabled alert");
        rreg(OFS_STATUS1, 8'h09, "high low");
        rreg(OFS_STATUS2, 8'h03, "out of range");
        wreg(OFS_CFG2, 8'h00);
        tmon(8'h64, 8'h64);
        chk({crit_n, thr_n, al_oe}, 8'h01, "crit pins");
        rreg(OFS_STATUS1, 8'hf5, "crit throttle");
        tmon(8'h64, 8'h00);
        rreg(OFS_STATUS1, 8'h11, "throttle held off");
        tmon(8'h54, 8'h00);
        chk({crit_n, thr_n}, 8'h03, "pins released");
        tmon(8'h64, 8'h00);
        rreg(OFS_STATUS1, 8'h51, "throttle rearmed");
        rreg(OFS_STATUS2, 8'h03, "local range");
        wreg(OFS_CFG2, 8'h18);
        tmon(8'h32, 8'h28);
        chk(al_oe, 1'b1, "passive alert");
        rreg(OFS_STATUS2, 8'h08, "auto passive");
        wreg(OFS_CFG2, 8'h28);
        tmon(8'h32, 8'h28);
        rreg(OFS_STATUS2, 8'h00, "max speed warm");
        tmon(8'h28, 8'h28);
        rreg(OFS_STATUS2, 8'h08, "max speed cool");
        wreg(OFS_FANCHAR, 8'h05);
        foreach (fan[i])
        begin
            wreg(OFS_CFG1, {7'h0, fan[i].inv});
            wreg(OFS_DUTY, fan[i].duty);
            wreg(OFS_CFG2, {7'h0, fan[i].en});
            // passive level only drops at a monitor cycle in software mode
            tmon(8'h32, 8'h28);
            repeat (3000) @(negedge clk);
            bad = 0;
            repeat (2600) @(negedge clk) bad += int'(fan_oe !== fan[i].oe);
            chk(8'(bad != 0), 8'h00, "fan level");
        end
        // 40 kHz is 80 ticks of 3.2 MHz, exactly 2500 clocks
        wreg(OFS_DUTY, 8'h80);
        @(posedge fan_oe);
        bad = 0;
        while (fan_oe === 1'b1 || bad < 10) @(negedge clk) bad++;
        while (fan_oe !== 1'b1) @(negedge clk) bad++;
        chk(8'(bad > 2497 && bad < 2503), 8'h01, "period");
        // low range period is far too long to time; it must hold the on phase
        rng = 1'b1;
        repeat (2600) @(negedge clk);
        bad = 0;
        repeat (2600) @(negedge clk) bad += int'(fan_oe !== 1'b0);
        chk(8'(bad != 0), 8'h00, "low range");
        for (int k = 0; k < 3; k++)
        begin
            wreg(OFS_CFG1, 8'h80);
            @(negedge clk);
            {d_open, d_gnd, d_pins} = 3'b100 >> k;
            tmon(8'h00, 8'h00);
            rreg(OFS_STATUS2, 8'h00, "no early fault");
            tmon(8'h00, 8'h00);
            chk(crit_n, 1'b0, "fault pin");
            rreg(OFS_REMOTE_HI, TEMP_FAULT_CODE, "fault code");
            rreg(OFS_STATUS2, 8'h06, "fault flag");
        end
        finish_test();
    end
endmodule
